// ---- rtl/ppx_port_pins.sv ----
// Summary of operation
// - output format and pull-up chosen per individual pin.
// - first port direction set per nibble, four pins together.
// - second and third port pins each have their own direction bit.
// - first port pull-up on with push-pull output, off with open drain.
// - second and third ports have software pull-ups for either output format.
// - first, second and third port pins each push-pull or open-drain.
// - first port inputs with pull-ups off in reset, selected pull-ups after.
// - second and third ports inputs with pull-ups off during reset.
// - input port keeps its fixed pull-ups during reset.
// - second port shares serial pins; timer pwm drives its top pin.
`default_nettype none
module ppx_port_pins (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [ppx_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ppx_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ppx_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [ppx_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] nibble_dir_port_pins_i,
   output logic [7:0] nibble_dir_port_pins_o,
   output logic [7:0] nibble_dir_port_pins_oe,
   output logic [7:0] nibble_dir_port_pins_pu,
   input wire logic [7:0] bitwise_port_a_pins_i,
   output logic [7:0] bitwise_port_a_pins_o,
   output logic [7:0] bitwise_port_a_pins_oe,
   output logic [7:0] bitwise_port_a_pins_pu,
   input wire logic [5:0] bitwise_port_b_pins_i,
   output logic [5:0] bitwise_port_b_pins_o,
   output logic [5:0] bitwise_port_b_pins_oe,
   output logic [5:0] bitwise_port_b_pins_pu,
   input wire logic input_port_pin_zero,
   input wire logic [2:0] input_port_upper_pins,
   input wire logic [3:0] input_port_pu_option,
   output logic [3:0] input_port_pu,
   input wire logic serial_channel_zero_dout,
   input wire logic serial_channel_zero_clk_out,
   output logic serial_channel_zero_din,
   output logic serial_channel_zero_clk_in,
   input wire logic timer1_pwm,
   input wire logic [3:0] irq_ack,
   output logic ext_irq_pending,
   output logic [7:0] irq_vector,
   output logic irq
);
   import ppx_pkg::*;

   // registers
   logic [7:0] p0_out_q, pa_out_q, pa_dir_q, pa_od_q;
   logic [5:0] pb_out_q, pb_dir_q, pb_od_q, pb_pu_q;
   logic [7:0] p0_od_q, p0_pu_q, pa_pu_q;
   logic [1:0] p0_dir_q;
   logic [7:0] irq_mode_q;
   logic [3:0] irq_mask_q, irq_stat_q, irq_stat_d;
   logic [3:0] alt_q;
   logic [3:0] irq_in_q;

   // bus slave
   ppx_bus_t bs_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_have_q, w_have_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire [7:0] wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_have_q ? wdata_q : s_axi_wdata;
   // strobes travel with the data beat, which may land before the address does
   wire [3:0] wr_strb = w_have_q ? wstrb_q : s_axi_wstrb;
   wire wr_fire = (bs_q == BS_IDLE) && (aw_have_q || aw_take) && (w_have_q || w_take);
   wire rd_fire = (bs_q == BS_IDLE) && !wr_fire && !aw_have_q && !w_have_q && s_axi_arvalid;
   wire wr_en = wr_fire && wr_strb[0];
   wire wr_en_mid = wr_fire && wr_strb[1];
   wire wr_en_hi = wr_fire && wr_strb[2];

   assign s_axi_awready = (bs_q == BS_IDLE) && !aw_have_q;
   assign s_axi_wready = (bs_q == BS_IDLE) && !w_have_q;
   assign s_axi_arready = rd_fire;
   assign s_axi_bvalid = (bs_q == BS_WRESP);
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = (bs_q == BS_RRESP);
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   wire wr_known = (wr_addr <= A_ALT_CFG) && (wr_addr[1:0] == 2'h0)
                   && (wr_addr != A_PIN_IN) && (wr_addr != A_IRQ_VEC) && (wr_addr != A_IRQ_STAT);

   // pin inputs and interrupt sources
   wire [3:0] irq_src = {input_port_upper_pins, input_port_pin_zero};
   wire [31:0] pin_in_w = {4'h0, irq_src, 2'h0, bitwise_port_b_pins_i, bitwise_port_a_pins_i,
                           nibble_dir_port_pins_i};

   // sensing: a,b support level, c,d use code 2 as both edges
   logic [3:0] hit_raw;
   logic irq_armed_q;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         unique case (irq_mode_q[2*i +: 2])
            SNS_RISE: hit_raw[i] = irq_src[i] && !irq_in_q[i];
            SNS_FALL: hit_raw[i] = !irq_src[i] && irq_in_q[i];
            SNS_HIGH: hit_raw[i] = (i < 2) ? irq_src[i] : (irq_src[i] != irq_in_q[i]);
            SNS_LOW: hit_raw[i] = (i < 2) ? !irq_src[i] : 1'b0;
         endcase
      end
   end
   // history flops clear to zero, so an idle-high pin would look like an edge right after reset;
   // sensing waits one cycle until the history holds the real pin levels
   wire [3:0] hit = hit_raw & {4{irq_armed_q}};

   wire rd_stat = rd_fire && (s_axi_araddr == A_IRQ_STAT);
   // set wins over clear from read or ack
   assign irq_stat_d = hit | (irq_stat_q & ~irq_ack & ~{4{rd_stat}});
   assign irq = |(irq_stat_q & irq_mask_q);
   assign ext_irq_pending = |irq_stat_q;

   logic [7:0] vec_d;
   always_comb begin
      vec_d = VEC_NONE;
      if (irq_stat_q[3] && irq_mask_q[3]) vec_d = VEC_D;
      if (irq_stat_q[2] && irq_mask_q[2]) vec_d = VEC_C;
      if (irq_stat_q[1] && irq_mask_q[1]) vec_d = VEC_B;
      if (irq_stat_q[0] && irq_mask_q[0]) vec_d = VEC_A;
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      unique case (s_axi_araddr)
         A_P0_OUT: rd_mux = {24'h0, p0_out_q};
         A_P0_CFG: rd_mux = {14'h0, p0_dir_q, p0_pu_q, p0_od_q};
         A_PA_OUT: rd_mux = {24'h0, pa_out_q};
         A_PA_DIR: rd_mux = {24'h0, pa_dir_q};
         A_PA_CFG: rd_mux = {16'h0, pa_pu_q, pa_od_q};
         A_PB_OUT: rd_mux = {26'h0, pb_out_q};
         A_PB_DIR: rd_mux = {26'h0, pb_dir_q};
         A_PB_PU: rd_mux = {16'h0, 2'h0, pb_pu_q, 2'h0, pb_od_q};
         A_PIN_IN: rd_mux = pin_in_w;
         A_IRQ_MODE: rd_mux = {24'h0, irq_mode_q};
         A_IRQ_STAT: rd_mux = {28'h0, irq_stat_q};
         A_IRQ_MASK: rd_mux = {28'h0, irq_mask_q};
         A_IRQ_VEC: rd_mux = {24'h0, vec_d};
         A_ALT_CFG: rd_mux = {28'h0, alt_q};
         default: rd_mux = 32'h0;
      endcase
   end
   wire rd_known = (s_axi_araddr <= A_ALT_CFG) && (s_axi_araddr[1:0] == 2'h0);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         bs_q <= BS_IDLE;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bresp_q <= RESP_OKAY;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0;
      end else begin
         unique case (bs_q)
            BS_IDLE: begin
               if (aw_take && !wr_fire) aw_have_q <= 1'b1;
               if (aw_take) awaddr_q <= s_axi_awaddr;
               if (w_take && !wr_fire) w_have_q <= 1'b1;
               if (w_take) wdata_q <= s_axi_wdata;
               if (w_take) wstrb_q <= s_axi_wstrb;
               if (wr_fire) begin
                  aw_have_q <= 1'b0;
                  w_have_q <= 1'b0;
                  bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
                  bs_q <= BS_WRESP;
               end else if (rd_fire) begin
                  rdata_q <= rd_mux;
                  rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
                  bs_q <= BS_RRESP;
               end
            end
            BS_WRESP: if (s_axi_bready) bs_q <= BS_IDLE;
            BS_RRESP: if (s_axi_rready) bs_q <= BS_IDLE;
         endcase
      end
   end

   // register file; all ports come out of reset as inputs, switchable pull-ups off
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         p0_out_q <= 8'h00;
         p0_od_q <= 8'h00;
         p0_pu_q <= 8'h00;
         p0_dir_q <= 2'h0;
         pa_out_q <= 8'h00;
         pa_dir_q <= 8'h00;
         pa_od_q <= 8'h00;
         pa_pu_q <= 8'h00;
         pb_out_q <= 6'h00;
         pb_dir_q <= 6'h00;
         pb_od_q <= 6'h00;
         pb_pu_q <= 6'h00;
         irq_mode_q <= 8'h00;
         irq_mask_q <= 4'h0;
         alt_q <= 4'h0;
      end else if (wr_fire) begin
         unique case (wr_addr)
            A_P0_OUT: if (wr_en) p0_out_q <= wr_data[7:0];
            A_P0_CFG: begin
               if (wr_en) p0_od_q <= wr_data[7:0];
               if (wr_en_mid) p0_pu_q <= wr_data[P0_PU_LSB +: 8];
               if (wr_en_hi) p0_dir_q <= wr_data[P0_DIR_HI:P0_DIR_LO];
            end
            A_PA_OUT: if (wr_en) pa_out_q <= wr_data[7:0];
            A_PA_DIR: if (wr_en) pa_dir_q <= wr_data[7:0];
            A_PA_CFG: begin
               if (wr_en) pa_od_q <= wr_data[7:0];
               if (wr_en_mid) pa_pu_q <= wr_data[15:8];
            end
            A_PB_OUT: if (wr_en) pb_out_q <= wr_data[5:0];
            A_PB_DIR: if (wr_en) pb_dir_q <= wr_data[5:0];
            A_PB_PU: begin
               if (wr_en) pb_od_q <= wr_data[5:0];
               if (wr_en_mid) pb_pu_q <= wr_data[13:8];
            end
            A_IRQ_MODE: if (wr_en) irq_mode_q <= wr_data[7:0];
            A_IRQ_MASK: if (wr_en) irq_mask_q <= wr_data[3:0];
            A_ALT_CFG: if (wr_en) alt_q <= wr_data[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq_stat_q <= 4'h0;
         irq_in_q <= 4'h0;
         irq_armed_q <= 1'b0;
         irq_vector <= VEC_NONE;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_in_q <= irq_src;
         irq_armed_q <= 1'b1;
         irq_vector <= vec_d;
      end
   end

   // pin drivers; open drain drives low only
   wire [7:0] p0_dir_w = {{4{p0_dir_q[1]}}, {4{p0_dir_q[0]}}};
   wire [7:0] p0_val = p0_out_q;
   assign nibble_dir_port_pins_o = p0_val & ~p0_od_q;
   assign nibble_dir_port_pins_oe = p0_dir_w & (~p0_od_q | ~p0_val);
   // pull-up only on push-pull pins, off in reset since regs are clear
   assign nibble_dir_port_pins_pu = p0_pu_q & ~p0_od_q;

   // alternate functions: serial out on pin0 (pin1 in bus mode, pin0 then high), clock on pin2, pwm on pin7
   logic [7:0] pa_val, pa_dir_eff;
   always_comb begin
      pa_val = pa_out_q;
      pa_dir_eff = pa_dir_q;
      if (alt_q[ALT_SER_OUT]) begin
         pa_val[0] = serial_channel_zero_dout;
         pa_dir_eff[0] = 1'b1;
      end
      if (alt_q[ALT_SER_BUS]) begin
         pa_val[1] = serial_channel_zero_dout;
         pa_dir_eff[1] = 1'b1;
         pa_val[0] = 1'b1;
      end
      if (alt_q[ALT_SER_CLK_OUT]) begin
         pa_val[2] = serial_channel_zero_clk_out;
         pa_dir_eff[2] = 1'b1;
      end
      if (alt_q[ALT_PWM]) begin
         pa_val[7] = timer1_pwm;
         pa_dir_eff[7] = 1'b1;
      end
   end
   assign serial_channel_zero_din = bitwise_port_a_pins_i[1];
   assign serial_channel_zero_clk_in = bitwise_port_a_pins_i[2];
   assign bitwise_port_a_pins_o = pa_val & ~pa_od_q;
   assign bitwise_port_a_pins_oe = pa_dir_eff & (~pa_od_q | ~pa_val);
   assign bitwise_port_a_pins_pu = pa_pu_q;
   assign bitwise_port_b_pins_o = pb_out_q & ~pb_od_q;
   assign bitwise_port_b_pins_oe = pb_dir_q & (~pb_od_q | ~pb_out_q);
   assign bitwise_port_b_pins_pu = pb_pu_q;
   // fixed option pull-ups, not gated by reset
   assign input_port_pu = input_port_pu_option;

   // checks
   p0_reset_a: assert property (@(posedge core_clk) reset |-> nibble_dir_port_pins_oe == 8'h00
      && nibble_dir_port_pins_pu == 8'h00) else $error("port0 not input in reset");
   pab_reset_a: assert property (@(posedge core_clk) reset |-> bitwise_port_a_pins_pu == 8'h00
      && bitwise_port_b_pins_oe == 6'h00) else $error("ports not released in reset");
   od_pullup_a: assert property (@(posedge core_clk) disable iff (reset)
      (nibble_dir_port_pins_pu & p0_od_q) == 8'h00) else $error("pull-up on open drain pin");
   nibble_dir_a: assert property (@(posedge core_clk) disable iff (reset)
      (nibble_dir_port_pins_oe[3:0] != 4'h0) |-> p0_dir_q[0]) else $error("nibble direction broken");
   irq_latch_a: assert property (@(posedge core_clk) disable iff (reset)
      hit[0] |=> irq_stat_q[0]) else $error("irq a not latched");
   irq_hold_a: assert property (@(posedge core_clk) disable iff (reset)
      irq_stat_q[1] && !irq_ack[1] && !rd_stat |=> irq_stat_q[1]) else $error("irq b dropped");
   vec_a_a: assert property (@(posedge core_clk) disable iff (reset)
      irq_stat_q[0] && irq_mask_q[0] |=> irq_vector == VEC_A) else $error("vector a wrong");
   pwm_route_a: assert property (@(posedge core_clk) disable iff (reset)
      alt_q[ALT_PWM] && !pa_od_q[7] |-> bitwise_port_a_pins_o[7] == timer1_pwm) else $error("pwm not routed");
   in_pu_a: assert property (@(posedge core_clk) input_port_pu == input_port_pu_option)
      else $error("input port pull-up wrong");
   nibble_hi_a: assert property (@(posedge core_clk) disable iff (reset)
      (nibble_dir_port_pins_oe[7:4] != 4'h0) |-> p0_dir_q[1]) else $error("upper nibble direction broken");
   // two-cycle irq behaviour, single-cycle conditions written as named sequences
   sequence ack_b_s;
      irq_ack[1] && !hit[1];
   endsequence
   sequence b_first_s;
      irq_stat_q[1] && irq_mask_q[1] && !(irq_stat_q[0] && irq_mask_q[0]);
   endsequence
   ack_clear_a: assert property (@(posedge core_clk) disable iff (reset) ack_b_s |=> !irq_stat_q[1])
      else $error("irq b not cleared by ack");
   vec_b_a: assert property (@(posedge core_clk) disable iff (reset) b_first_s |=> irq_vector == VEC_B)
      else $error("vector b wrong");
   od_high_a: assert property (@(posedge core_clk) disable iff (reset)
      (bitwise_port_a_pins_oe & bitwise_port_a_pins_o & pa_od_q) == 8'h00) else $error("open drain drives high");
   pb_dir_a: assert property (@(posedge core_clk) disable iff (reset)
      (bitwise_port_b_pins_oe & ~pb_dir_q) == 6'h00) else $error("port b drives an input pin");
   p0_release_a: assert property (@(posedge core_clk) $fell(reset) |-> nibble_dir_port_pins_pu == 8'h00)
      else $error("pull-up on before software selects it");
endmodule : ppx_port_pins
`default_nettype wire

// ---- rtl/ppx_pkg.sv ----
`default_nettype none
package ppx_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // register byte addresses
   localparam logic [7:0] A_P0_OUT = 8'h00;
   localparam logic [7:0] A_P0_CFG = 8'h04;
   localparam logic [7:0] A_PA_OUT = 8'h08;
   localparam logic [7:0] A_PA_DIR = 8'h0C;
   localparam logic [7:0] A_PA_CFG = 8'h10;
   localparam logic [7:0] A_PB_OUT = 8'h14;
   localparam logic [7:0] A_PB_DIR = 8'h18;
   localparam logic [7:0] A_PB_PU = 8'h1C;
   localparam logic [7:0] A_PIN_IN = 8'h20;
   localparam logic [7:0] A_IRQ_MODE = 8'h24;
   localparam logic [7:0] A_IRQ_STAT = 8'h28;
   localparam logic [7:0] A_IRQ_MASK = 8'h2C;
   localparam logic [7:0] A_IRQ_VEC = 8'h30;
   localparam logic [7:0] A_ALT_CFG = 8'h34;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // interrupt vectors
   localparam logic [7:0] VEC_A = 8'h03;
   localparam logic [7:0] VEC_B = 8'h0B;
   localparam logic [7:0] VEC_C = 8'h13;
   localparam logic [7:0] VEC_D = 8'h1B;
   localparam logic [7:0] VEC_NONE = 8'h00;
   // sensing modes, 2 bits per input
   localparam logic [1:0] SNS_RISE = 2'h0;
   localparam logic [1:0] SNS_FALL = 2'h1;
   localparam logic [1:0] SNS_HIGH = 2'h2;
   localparam logic [1:0] SNS_LOW = 2'h3;
   localparam logic [1:0] SNS_BOTH = 2'h2;
   // field positions
   localparam int P0_PU_LSB = 8;
   localparam int P0_DIR_LO = 16;
   localparam int P0_DIR_HI = 17;
   localparam int ALT_SER_OUT = 0;
   localparam int ALT_SER_CLK_OUT = 1;
   localparam int ALT_SER_BUS = 2;
   localparam int ALT_PWM = 3;
   localparam int PIN_IRQ = 3;
   typedef enum logic [2:0] {
      BS_IDLE = 3'b001,
      BS_WRESP = 3'b010,
      BS_RRESP = 3'b100
   } ppx_bus_t;
endpackage : ppx_pkg
`default_nettype wire

// ---- dv/ppx_pin_world.sv ----
`default_nettype none
module ppx_pin_world #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic [W-1:0] o,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] pu,
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [W-1:0] float_q;
   initial float_q = '0;
   // a pin nobody drives or pulls keeps flipping, so no stale level can pass a check
   always @(posedge core_clk) float_q <= ~float_q;
   assign level = (oe & o) | (~oe & ((ext_en & ext_val) | (~ext_en & (pu | float_q))));
endmodule : ppx_pin_world
`default_nettype wire

// ---- dv/ppx_port_pins_bench.sv ----
`default_nettype none
module ppx_port_pins_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import ppx_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; int port; logic [7:0] oe; logic [7:0] pu;} ppx_row_t;
   logic core_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, input_port_pin_zero;
   logic serial_channel_zero_dout, serial_channel_zero_clk_out, serial_channel_zero_din;
   logic serial_channel_zero_clk_in, timer1_pwm, ext_irq_pending, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr, irq_vector, e0_en, e0_val, ea_en, ea_val;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb, input_port_pu_option, input_port_pu, irq_ack;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0] input_port_upper_pins;
   logic [7:0] nibble_dir_port_pins_i, nibble_dir_port_pins_o, nibble_dir_port_pins_oe, nibble_dir_port_pins_pu;
   logic [7:0] bitwise_port_a_pins_i, bitwise_port_a_pins_o, bitwise_port_a_pins_oe, bitwise_port_a_pins_pu;
   logic [5:0] bitwise_port_b_pins_i, bitwise_port_b_pins_o, bitwise_port_b_pins_oe, bitwise_port_b_pins_pu;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] vecs [4] = '{8'h03, 8'h0B, 8'h13, 8'h1B};
   ppx_row_t rows [9] = '{
      '{A_P0_OUT, 32'h000000FF, 0, 8'h00, 8'h00}, '{A_P0_CFG, 32'h0001FF05, 0, 8'h0A, 8'hFA},
      '{A_P0_CFG, 32'h0003FF05, 0, 8'hFA, 8'hFA}, '{A_PA_OUT, 32'h0000000F, 1, 8'h00, 8'h00},
      '{A_PA_DIR, 32'h000000A5, 1, 8'hA5, 8'h00}, '{A_PA_CFG, 32'h0000FF01, 1, 8'hA4, 8'hFF},
      '{A_PB_DIR, 32'h0000003C, 2, 8'h3C, 8'h00}, '{A_PB_PU, 32'h0000153F, 2, 8'h3C, 8'h15},
      '{A_PB_OUT, 32'h0000003F, 2, 8'h00, 8'h15}};

   ppx_port_pins i_ppx_port_pins (.*);
   ppx_pin_world #(.W(8)) i_ppx_pin_world_p0 (.core_clk(core_clk), .o(nibble_dir_port_pins_o),
      .oe(nibble_dir_port_pins_oe), .pu(nibble_dir_port_pins_pu), .ext_en(e0_en), .ext_val(e0_val),
      .level(nibble_dir_port_pins_i));
   ppx_pin_world #(.W(8)) i_ppx_pin_world_pa (.core_clk(core_clk), .o(bitwise_port_a_pins_o),
      .oe(bitwise_port_a_pins_oe), .pu(bitwise_port_a_pins_pu), .ext_en(ea_en), .ext_val(ea_val),
      .level(bitwise_port_a_pins_i));
   ppx_pin_world #(.W(6)) i_ppx_pin_world_pb (.core_clk(core_clk), .o(bitwise_port_b_pins_o),
      .oe(bitwise_port_b_pins_oe), .pu(bitwise_port_b_pins_pu), .ext_en(6'h00), .ext_val(6'h00),
      .level(bitwise_port_b_pins_i));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_d, w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!(aw_d && w_d)) begin
         @(posedge core_clk);
         if (!aw_d && s_axi_awready === 1'b1) begin
            aw_d = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_d && s_axi_wready === 1'b1) begin
            w_d = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      @(posedge core_clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
      {rsp, rdat} = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   // flip one interrupt pin for two cycles, then give the sensing time to land
   task automatic pulse(input int i);
      @(posedge core_clk);
      {input_port_upper_pins, input_port_pin_zero} <= {input_port_upper_pins, input_port_pin_zero} ^ 4'(1 << i);
      repeat (2) @(posedge core_clk);
      {input_port_upper_pins, input_port_pin_zero} <= {input_port_upper_pins, input_port_pin_zero} ^ 4'(1 << i);
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
   endtask : pulse

   task automatic reset_check;
      chk({nibble_dir_port_pins_oe, bitwise_port_a_pins_oe, bitwise_port_b_pins_oe}, 0);
      chk({nibble_dir_port_pins_pu, bitwise_port_a_pins_pu, bitwise_port_b_pins_pu}, 0);
      chk(input_port_pu, 4'hA);
   endtask : reset_check

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr} = '0;
      {s_axi_araddr, s_axi_wdata, s_axi_wstrb, irq_ack, input_port_pin_zero, timer1_pwm} = '0;
      {serial_channel_zero_dout, serial_channel_zero_clk_out, e0_en, e0_val, ea_en, ea_val} = '0;
      {input_port_upper_pins, input_port_pu_option, reset} = {3'h7, 4'hA, 1'b1};
      repeat (6) @(posedge core_clk);
      reset_check();
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         axi_wr(rows[i].a, rows[i].d);
         chk(rsp, RESP_OKAY);
         @(negedge core_clk);
         chk(rows[i].port == 0 ? nibble_dir_port_pins_oe : rows[i].port == 1 ? bitwise_port_a_pins_oe :
            {2'h0, bitwise_port_b_pins_oe}, rows[i].oe);
         chk(rows[i].port == 0 ? nibble_dir_port_pins_pu : rows[i].port == 1 ? bitwise_port_a_pins_pu :
            {2'h0, bitwise_port_b_pins_pu}, rows[i].pu);
      end
      @(posedge core_clk);
      {e0_en, ea_en, timer1_pwm} <= {8'h05, 8'h02, 1'b1};
      axi_wr(A_ALT_CFG, 32'h9);
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      // pin 0 is open drain here, so its level, not the drive value, shows the serial bit
      chk({bitwise_port_a_pins_o[7], bitwise_port_a_pins_i[0], serial_channel_zero_din,
         serial_channel_zero_clk_in}, 4'b1001);
      @(posedge core_clk);
      {ea_val, timer1_pwm, serial_channel_zero_dout} <= {8'h02, 2'b01};
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk({bitwise_port_a_pins_o[7], bitwise_port_a_pins_i[0], serial_channel_zero_din,
         serial_channel_zero_clk_in}, 4'b0111);
      axi_wr(A_ALT_CFG, 32'h6);
      @(negedge core_clk);
      chk({bitwise_port_a_pins_o[2:1], bitwise_port_a_pins_oe[2:1]}, 4'b0111);
      axi_rd(A_PIN_IN);
      chk(rdat[7:0], 8'hFA);
      axi_wr(A_PIN_IN, 32'h1);
      chk(rsp, RESP_SLVERR);
      axi_wr(8'h3C, 32'h1);
      chk(rsp, RESP_SLVERR);
      axi_rd(8'h3C);
      chk(rsp, RESP_SLVERR);
      chk(rdat, 32'h0);
      axi_wr(A_IRQ_MODE, 32'h6C);
      axi_wr(A_IRQ_MASK, 32'h0);
      axi_rd(A_IRQ_STAT);
      pulse(0);
      chk({ext_irq_pending, irq}, 2'b10);
      axi_rd(A_IRQ_STAT);
      chk(rdat, 32'h1);
      axi_rd(A_IRQ_STAT);
      chk(rdat, 32'h0);
      for (int i = 0; i < 4; i++) begin
         axi_wr(A_IRQ_MASK, 32'(1 << i));
         pulse(i);
         chk({irq, irq_vector}, {1'b1, vecs[i]});
         @(posedge core_clk);
         irq_ack <= 4'(1 << i);
         @(posedge core_clk);
         irq_ack <= 4'h0;
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         chk({ext_irq_pending, irq}, 2'b00);
      end
      // a second reset mid-run must drop every driver and switchable pull-up again
      axi_wr(A_P0_CFG, 32'h0003FF00);
      reset <= 1'b1;
      repeat (2) @(negedge core_clk);
      reset_check();
      tally_and_finish();
   end
endmodule : ppx_port_pins_bench
`default_nettype wire
